/* File: core/pkey_pkg.sv */
// Purpose: Shared constants for the power-key press classifier.
// Assumes: 50 MHz clock, APB register access, one word per register.
// Notes: Timings are held in milliseconds and counted on a 1 ms tick.
package pkey_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PEND_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  // Control/status field positions.
  localparam int THR_LSB = 7;
  localparam int HOLD_EN_BIT = 6;
  localparam int HOLD_SEL_LSB = 4;
  localparam int TOGGLE_BIT = 3;
  localparam int LVL_TWO_BIT = 2;
  localparam int LVL_ONE_BIT = 1;
  localparam int PRESSED_BIT = 0;
  // Pending and mask field positions.
  localparam int LONG_PEND_BIT = 15;
  localparam int SHORT_PEND_BIT = 14;
  // Reset values.
  localparam logic [2:0] THR_RESET = 3'h1;
  localparam logic HOLD_EN_RESET = 1'b1;
  localparam logic [1:0] HOLD_SEL_RESET = 2'h0;
  localparam logic TOGGLE_RESET = 1'b1;
  // Timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [14:0] DEBOUNCE_MS = 15'h0032;
  localparam logic [14:0] THR_MS_0 = 15'h007d;
  localparam logic [14:0] THR_MS_1 = 15'h00fa;
  localparam logic [14:0] THR_MS_2 = 15'h01f4;
  localparam logic [14:0] THR_MS_3 = 15'h03e8;
  localparam logic [14:0] THR_MS_4 = 15'h05dc;
  localparam logic [14:0] THR_MS_5 = 15'h07d0;
  localparam logic [14:0] THR_MS_6 = 15'h0bb8;
  localparam logic [14:0] THR_MS_7 = 15'h0fa0;
  localparam logic [14:0] HOLD_MS_0 = 15'h1f40;
  localparam logic [14:0] HOLD_MS_1 = 15'h2ee0;
  localparam logic [14:0] HOLD_MS_2 = 15'h3e80;
  localparam logic [14:0] HOLD_MS_3 = 15'h5dc0;
  // Press tracking states, Gray coded along idle, held, long, reset issued.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HELD = 2'b01,
    ST_LONG = 2'b11,
    ST_RST_DONE = 2'b10
  } press_state_t;
endpackage : pkey_pkg

/* File: core/power_key_press_classifier.sv */
// Purpose: Power-key press timer, short/long classifier and hold-to-reset.
// Assumes: Key and level inputs are asynchronous pins; APB master on clock.
// Notes: Pending bits are write-one-to-clear; an event in the clear cycle wins.
//
// Functional notes
// - ignore under 50 ms; short below threshold, else long.
// - bits 9:7 select long threshold 0.125-4 s.
// - threshold field resets to code 001, read-write.
// - bit 6 enables hold-to-reset, set after reset.
// - bits 5:4 select reset hold 8/12/16/24 s.
// - bit 3 shows toggle state, reset one.
// - bit 2 shows pin at two-thirds level.
// - bit 1 shows pin at one-third level.
// - bit 0 shows key pressed.
// - long and short each set sticky pending flag.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module power_key_press_classifier #(
  parameter int TICK_CYCLES = pkey_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_key,
  input wire logic level_two_thirds_in,
  input wire logic level_one_third_in,
  output logic sys_reset_req,
  output logic irq
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [14:0] thr_ms(input logic [2:0] sel);
    case (sel)
      3'h0: thr_ms = pkey_pkg::THR_MS_0;
      3'h1: thr_ms = pkey_pkg::THR_MS_1;
      3'h2: thr_ms = pkey_pkg::THR_MS_2;
      3'h3: thr_ms = pkey_pkg::THR_MS_3;
      3'h4: thr_ms = pkey_pkg::THR_MS_4;
      3'h5: thr_ms = pkey_pkg::THR_MS_5;
      3'h6: thr_ms = pkey_pkg::THR_MS_6;
      default: thr_ms = pkey_pkg::THR_MS_7;
    endcase
  endfunction : thr_ms

  function automatic logic [14:0] hold_ms(input logic [1:0] sel);
    case (sel)
      2'h0: hold_ms = pkey_pkg::HOLD_MS_0;
      2'h1: hold_ms = pkey_pkg::HOLD_MS_1;
      2'h2: hold_ms = pkey_pkg::HOLD_MS_2;
      default: hold_ms = pkey_pkg::HOLD_MS_3;
    endcase
  endfunction : hold_ms

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit 0 key, bit 1 two-thirds level, bit 2 one-third level.
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_reg;
  logic key_filt;
  logic lvl_two_filt;
  logic lvl_one_filt;

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      pin_reg <= 3'h0;
    end else begin
      sync1_reg <= {level_one_third_in, level_two_thirds_in, power_key};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // A change counts only once two stages agree, which drops single-cycle glitches.
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  assign key_filt = pin_reg[0];
  assign lvl_two_filt = pin_reg[1];
  assign lvl_one_filt = pin_reg[2];

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] thr_sel_reg;
  logic hold_en_reg;
  logic [1:0] hold_sel_reg;
  logic toggle_reg;
  logic long_pend_reg;
  logic short_pend_reg;
  logic long_mask_reg;
  logic short_mask_reg;
  logic [31:0] prdata_reg;
  logic setup;
  logic wr_access;
  logic mapped;
  logic long_event;
  logic short_event;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign mapped = (paddr == pkey_pkg::CTRL_OFFSET) || (paddr == pkey_pkg::PEND_OFFSET)
    || (paddr == pkey_pkg::MASK_OFFSET);
  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      thr_sel_reg <= pkey_pkg::THR_RESET;
      hold_en_reg <= pkey_pkg::HOLD_EN_RESET;
      hold_sel_reg <= pkey_pkg::HOLD_SEL_RESET;
    end else if (wr_access && paddr == pkey_pkg::CTRL_OFFSET) begin
      thr_sel_reg <= pwdata[pkey_pkg::THR_LSB +: 3];
      hold_en_reg <= pwdata[pkey_pkg::HOLD_EN_BIT];
      hold_sel_reg <= pwdata[pkey_pkg::HOLD_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      long_mask_reg <= 1'b0;
      short_mask_reg <= 1'b0;
    end else if (wr_access && paddr == pkey_pkg::MASK_OFFSET) begin
      long_mask_reg <= pwdata[pkey_pkg::LONG_PEND_BIT];
      short_mask_reg <= pwdata[pkey_pkg::SHORT_PEND_BIT];
    end
  end

  // Pending flags: a new event beats a write-one clear in the same cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      long_pend_reg <= 1'b0;
      short_pend_reg <= 1'b0;
    end else begin
      if (long_event) begin
        long_pend_reg <= 1'b1;
      end else if (wr_access && paddr == pkey_pkg::PEND_OFFSET && pwdata[pkey_pkg::LONG_PEND_BIT]) begin
        long_pend_reg <= 1'b0;
      end
      if (short_event) begin
        short_pend_reg <= 1'b1;
      end else if (wr_access && paddr == pkey_pkg::PEND_OFFSET && pwdata[pkey_pkg::SHORT_PEND_BIT]) begin
        short_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (long_pend_reg && long_mask_reg) || (short_pend_reg && short_mask_reg);
    end
  end

  // Read data is captured in the setup cycle so that it comes from a flip-flop.
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_reg <= 32'h0000_0000;
      case (paddr)
        pkey_pkg::CTRL_OFFSET: begin
          prdata_reg[pkey_pkg::THR_LSB +: 3] <= thr_sel_reg;
          prdata_reg[pkey_pkg::HOLD_EN_BIT] <= hold_en_reg;
          prdata_reg[pkey_pkg::HOLD_SEL_LSB +: 2] <= hold_sel_reg;
          prdata_reg[pkey_pkg::TOGGLE_BIT] <= toggle_reg;
          prdata_reg[pkey_pkg::LVL_TWO_BIT] <= lvl_two_filt;
          prdata_reg[pkey_pkg::LVL_ONE_BIT] <= lvl_one_filt;
          prdata_reg[pkey_pkg::PRESSED_BIT] <= key_filt;
        end
        pkey_pkg::PEND_OFFSET: begin
          prdata_reg[pkey_pkg::LONG_PEND_BIT] <= long_pend_reg;
          prdata_reg[pkey_pkg::SHORT_PEND_BIT] <= short_pend_reg;
        end
        pkey_pkg::MASK_OFFSET: begin
          prdata_reg[pkey_pkg::LONG_PEND_BIT] <= long_mask_reg;
          prdata_reg[pkey_pkg::SHORT_PEND_BIT] <= short_mask_reg;
        end
        default: begin
          prdata_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // Toggle-switch state
  // ****************************************
  // The switch is on after the pin settles at one third and off at two thirds.
  always_ff @(posedge clock) begin
    if (rst) begin
      toggle_reg <= pkey_pkg::TOGGLE_RESET;
    end else if (lvl_one_filt && !lvl_two_filt) begin
      toggle_reg <= 1'b1;
    end else if (lvl_two_filt && !lvl_one_filt) begin
      toggle_reg <= 1'b0;
    end
  end

  // ****************************************
  // Press timer and classifier
  // ****************************************
  pkey_pkg::press_state_t state_reg;
  pkey_pkg::press_state_t state_next;
  logic [31:0] tick_cnt_reg;
  logic [14:0] ms_cnt_reg;
  logic tick;
  logic at_thr;
  logic at_hold;

  assign tick = (tick_cnt_reg == TICK_CYCLES - 1);
  assign at_thr = (ms_cnt_reg >= thr_ms(thr_sel_reg));
  assign at_hold = (ms_cnt_reg >= hold_ms(hold_sel_reg));

  // Time is measured from the press edge: both counters sit at zero while idle.
  always_ff @(posedge clock) begin
    if (rst || state_reg == pkey_pkg::ST_IDLE) begin
      tick_cnt_reg <= 32'h0000_0000;
      ms_cnt_reg <= 15'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
      if (ms_cnt_reg != 15'h7fff) begin
        ms_cnt_reg <= ms_cnt_reg + 15'h0001;
      end
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  always_comb begin
    state_next = state_reg;
    long_event = 1'b0;
    short_event = 1'b0;
    case (state_reg)
      pkey_pkg::ST_IDLE: begin
        if (key_filt) begin
          state_next = pkey_pkg::ST_HELD;
        end
      end
      pkey_pkg::ST_HELD: begin
        if (!key_filt) begin
          state_next = pkey_pkg::ST_IDLE;
          short_event = (ms_cnt_reg >= pkey_pkg::DEBOUNCE_MS);
        end else if (at_thr) begin
          state_next = pkey_pkg::ST_LONG;
          long_event = 1'b1;
        end
      end
      pkey_pkg::ST_LONG: begin
        if (!key_filt) begin
          state_next = pkey_pkg::ST_IDLE;
        end else if (hold_en_reg && at_hold) begin
          state_next = pkey_pkg::ST_RST_DONE;
        end
      end
      pkey_pkg::ST_RST_DONE: begin
        if (!key_filt) begin
          state_next = pkey_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = pkey_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= pkey_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // One-cycle reset request, only on the transition into the reset-issued state.
  always_ff @(posedge clock) begin
    if (rst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= (state_reg == pkey_pkg::ST_LONG) && (state_next == pkey_pkg::ST_RST_DONE);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_short_release;
    state_reg == pkey_pkg::ST_HELD && !key_filt && ms_cnt_reg >= pkey_pkg::DEBOUNCE_MS;
  endsequence

  sequence s_glitch_release;
    state_reg == pkey_pkg::ST_HELD && !key_filt && ms_cnt_reg < pkey_pkg::DEBOUNCE_MS;
  endsequence

  a_short_on_release: assert property (@(posedge clock) disable iff (rst)
    s_short_release |=> short_pend_reg && state_reg == pkey_pkg::ST_IDLE)
    else $error("short press not flagged on release");

  a_glitch_ignored: assert property (@(posedge clock) disable iff (rst)
    s_glitch_release ##0 !short_pend_reg |=> !short_pend_reg)
    else $error("press under debounce time was flagged");

  a_long_at_thr: assert property (@(posedge clock) disable iff (rst)
    state_reg == pkey_pkg::ST_HELD && key_filt && ms_cnt_reg >= thr_ms(thr_sel_reg)
    |=> long_pend_reg && state_reg == pkey_pkg::ST_LONG)
    else $error("long press not flagged at threshold");

  a_reset_values: assert property (@(posedge clock)
    rst |=> thr_sel_reg == 3'h1 && hold_en_reg && hold_sel_reg == 2'h0 && toggle_reg)
    else $error("control fields wrong after reset");

  a_reset_gated: assert property (@(posedge clock) disable iff (rst)
    $rose(sys_reset_req) |-> $past(hold_en_reg) && $past(state_reg == pkey_pkg::ST_LONG))
    else $error("reset issued while disabled");

  a_reset_time: assert property (@(posedge clock) disable iff (rst)
    sys_reset_req |-> $past(ms_cnt_reg) >= hold_ms($past(hold_sel_reg)) ##1 !sys_reset_req)
    else $error("reset issued before hold time");

  a_toggle_track: assert property (@(posedge clock) disable iff (rst)
    lvl_one_filt && !lvl_two_filt |=> toggle_reg)
    else $error("toggle state did not follow one-third level");

  a_level_read: assert property (@(posedge clock) disable iff (rst)
    setup && !pwrite && paddr == pkey_pkg::CTRL_OFFSET
    |=> prdata[2] == $past(lvl_two_filt) && prdata[1] == $past(lvl_one_filt) && prdata[0] == $past(key_filt))
    else $error("level flags misreported");

  a_pend_sticky: assert property (@(posedge clock) disable iff (rst)
    long_pend_reg && !(wr_access && paddr == pkey_pkg::PEND_OFFSET) |=> long_pend_reg)
    else $error("long pending cleared without write");

  a_release_cancel: assert property (@(posedge clock) disable iff (rst)
    state_reg == pkey_pkg::ST_LONG && !key_filt |=> state_reg == pkey_pkg::ST_IDLE && !sys_reset_req ##1 !sys_reset_req)
    else $error("reset not cancelled by release");

  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    long_pend_reg && long_mask_reg |=> irq)
    else $error("interrupt missing for unmasked pending");

endmodule : power_key_press_classifier

/* File: bench/pkey_partner.sv */
// Purpose: Model of the push key and the level comparators at the key pin.
// Assumes: Key pin is high while held; comparators report levels directly.
// Notes: Driven only from the bench through the two tasks below.
`timescale 1ns/1ps
module pkey_partner (
  input wire logic clock,
  output logic power_key,
  output logic level_two_thirds_in,
  output logic level_one_third_in
);
  initial begin
    power_key = 1'b0;
    level_two_thirds_in = 1'b0;
    level_one_third_in = 1'b0;
  end

  // A released key goes back to low, the idle level of the pin.
  task hold_key(input int cycles);
    @(posedge clock);
    power_key <= 1'b1;
    repeat (cycles) @(posedge clock);
    power_key <= 1'b0;
  endtask : hold_key

  task set_levels(input logic two, input logic one);
    @(posedge clock);
    level_two_thirds_in <= two;
    level_one_third_in <= one;
  endtask : set_levels
endmodule : pkey_partner

/* File: bench/test_power_key_press_classifier.sv */
// Purpose: Self-checking bench for the power-key press classifier.
// Assumes: One 1 ms tick is shortened to TICK clock cycles.
// Notes: Only the 8 s hold-reset time is timed; of the other codes only 24 s (code 3) is checked, as storage.
`timescale 1ns/1ps
module test_power_key_press_classifier;
  localparam int TICK = 2;
  localparam logic [7:0] BAD_OFFSET = 8'h0c;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_key;
  logic level_two;
  logic level_one;
  logic sys_reset_req;
  logic irq;
  logic [31:0] q;
  logic e;
  logic [31:0] mask_v = 32'h0;
  int err_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  int thr_ms[8] = '{125, 250, 500, 1000, 1500, 2000, 3000, 4000};

  always #10 clock = ~clock;
  always @(posedge clock) if (sys_reset_req === 1'b1) pulses <= pulses + 1;

  power_key_press_classifier #(.TICK_CYCLES(TICK)) dut_u (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_key(power_key), .level_two_thirds_in(level_two),
    .level_one_third_in(level_one), .sys_reset_req(sys_reset_req), .irq(irq));
  pkey_partner partner_u (.clock(clock), .power_key(power_key), .level_two_thirds_in(level_two),
    .level_one_third_in(level_one));

  task report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One transfer; the request stands until pready is seen high at an edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      err_count++;
      $display("[FAIL] %0t no ready", $time);
      report_and_stop();
    end
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd_chk

  // Hold the key, then read and clear the pending flags; irq follows the mask.
  task press_chk(input int ms, input logic [31:0] exp);
    partner_u.hold_key(ms * TICK);
    repeat (12) @(posedge clock);
    rd_chk(pkey_pkg::PEND_OFFSET, exp);
    check({31'h0, irq}, {31'h0, (exp & mask_v) != 32'h0});
    apb(1'b1, pkey_pkg::PEND_OFFSET, 32'hffffffff);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    rd_chk(pkey_pkg::PEND_OFFSET, 32'h0);
  endtask : press_chk

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd_chk(pkey_pkg::CTRL_OFFSET, 32'h000000c8);
    rd_chk(pkey_pkg::PEND_OFFSET, 32'h0);
    rd_chk(pkey_pkg::MASK_OFFSET, 32'h0);
    apb(1'b1, BAD_OFFSET, 32'hffffffff);
    check({31'h0, e}, 32'h1);
    apb(1'b0, BAD_OFFSET, 32'h0);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    apb(1'b1, pkey_pkg::CTRL_OFFSET, 32'hffffffff);
    rd_chk(pkey_pkg::CTRL_OFFSET, 32'h000003f8);
    partner_u.set_levels(1'b1, 1'b0);
    repeat (8) @(posedge clock);
    rd_chk(pkey_pkg::CTRL_OFFSET, 32'h000003f4);
    partner_u.set_levels(1'b0, 1'b1);
    repeat (8) @(posedge clock);
    rd_chk(pkey_pkg::CTRL_OFFSET, 32'h000003fa);
    partner_u.set_levels(1'b0, 1'b0);
    mask_v = 32'h00004000;
    apb(1'b1, pkey_pkg::MASK_OFFSET, mask_v);
    fork
      press_chk(47, 32'h0);
      begin
        repeat (60) @(posedge clock);
        rd_chk(pkey_pkg::CTRL_OFFSET, 32'h000003f9);
      end
    join
    press_chk(53, 32'h00004000);
    for (int c = 0; c < 8; c++) begin
      if (c == 4) begin
        mask_v = 32'h0000c000;
        apb(1'b1, pkey_pkg::MASK_OFFSET, mask_v);
      end
      apb(1'b1, pkey_pkg::CTRL_OFFSET, 32'(c) << 7);
      rd_chk(pkey_pkg::CTRL_OFFSET, (32'(c) << 7) | 32'h8);
      press_chk(thr_ms[c] - 3, 32'h00004000);
      press_chk(thr_ms[c] + 3, 32'h00008000);
    end
    apb(1'b1, pkey_pkg::CTRL_OFFSET, 32'h00000040);
    partner_u.hold_key(7990 * TICK);
    repeat (12) @(posedge clock);
    check(pulses, 32'h0);
    partner_u.hold_key(8010 * TICK);
    repeat (12) @(posedge clock);
    check(pulses, 32'h1);
    // A second reset in mid-run must bring back every reset value, pending flags included.
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd_chk(pkey_pkg::CTRL_OFFSET, 32'h000000c8);
    rd_chk(pkey_pkg::PEND_OFFSET, 32'h0);
    rd_chk(pkey_pkg::MASK_OFFSET, 32'h0);
    report_and_stop();
  end
endmodule : test_power_key_press_classifier
